//--- logic/crd_cfg.svh
// Constants for the command decoder: field codes, addresses and register layout
`ifndef CRD_CFG_SVH
`define CRD_CFG_SVH
`define CRD_CMD_READ 4'h0
`define CRD_CMD_WRITE 4'h8
`define CRD_CMD_ENTER 4'hB
`define CRD_GLOBAL_ADDR 4'h0
`define CRD_NODE_ADDR_IDX 8'h11
`define CRD_COLLECT_IDX 8'h12
`define CRD_FILE_BASE 8'h10
`define CRD_FILE_DEPTH 16
`define CRD_NODE_ADDR_RST 4'h0
`define CRD_FILE_RST 8'h00
`endif

//--- logic/crd_pkg.sv
// Types for the command decoder
package crd_pkg;
    typedef struct packed {
        logic [3:0] nodeAddr;
        logic [3:0] cmd;
        logic [7:0] index;
        logic [7:0] data;
    } crd_cmd_s;
    typedef struct packed {
        logic [3:0] nodeAddr;
        logic [3:0] cmd;
        logic [7:0] dataHi;
        logic [7:0] dataLo;
    } crd_rsp_s;
endpackage

//--- logic/crd_command_decoder.sv
// Command-and-response frame decoder with a small local register file
// How it works
// - Code 0000 requests a register read; response echoes 0000.
// - Read answered only when target node address equals stored node address.
// - Reads to other addresses, broadcast included, are dropped without response.
// - Read of an unreadable index still responds with zero data; for 0x0F the upper byte holds register 0x10.
// - Response upper byte holds register index+1, lower byte register index.
// - Response address field carries the stored node address.
// - Matching write is performed and then answered.
// - Non-matching or broadcast writes dropped, except broadcast node address write.
// - Write to an unwritable index responds with zero data.
// - Code 1000 is a write; response echoes 1000.
// - Broadcast node address write accepted only while stored address is 0000.
// - Broadcast enter-collection sets enable bit and sends no response.
`timescale 1ns/1ps
`include "crd_cfg.svh"
module crd_command_decoder
    import crd_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic cmdValid, // One-cycle strobe, frame checked upstream
    input wire crd_cmd_s cmdFrame, // Decoded command fields
    output logic rspValid, // One-cycle strobe, response fields ready
    output crd_rsp_s rspFrame, // Response fields
    output logic [3:0] nodeAddr, // Stored node address
    output logic collectEnable // Periodic collection enable bit
);
    // ==========================================================
    // Register file
    // Index 0x10..0x1F live here; 0x11 is the node address, 0x12 holds
    // the collection enable in bit 0. The rest are plain read/write bytes.
    logic [7:0] file_q [`CRD_FILE_DEPTH];
    logic [7:0] file_d [`CRD_FILE_DEPTH];
    crd_rsp_s rsp_q, rsp_d;
    logic rspValid_q, rspValid_d;

    function automatic logic inFile(input logic [7:0] idx);
        return (idx & 8'hF0) == `CRD_FILE_BASE;
    endfunction

    // Slot within the file; only meaningful once inFile has said yes
    function automatic logic [3:0] slotOf(input logic [7:0] idx);
        return idx[3:0];
    endfunction

    // Reads outside the file return zero
    function automatic logic [7:0] readByte(input logic [7:0] idx,
                                            input logic [7:0] f [`CRD_FILE_DEPTH]);
        return inFile(idx) ? f[idx[3:0]] : `CRD_FILE_RST;
    endfunction

    logic [3:0] storedAddr;
    logic addrMatch, isGlobal, doWrite, doRead, doEnter, answer;
    logic [7:0] nextIdx;

    assign storedAddr = file_q[slotOf(`CRD_NODE_ADDR_IDX)][3:0];
    assign addrMatch = cmdFrame.nodeAddr == storedAddr;
    assign isGlobal = cmdFrame.nodeAddr == `CRD_GLOBAL_ADDR;
    assign nextIdx = cmdFrame.index + 8'h01;

    // ==========================================================
    // Decode
    always_comb begin
        doRead = 1'b0;
        doWrite = 1'b0;
        doEnter = 1'b0;
        answer = 1'b0;
        if (cmdValid) begin
            unique case (cmdFrame.cmd)
                `CRD_CMD_READ: begin
                    // Broadcast address never answers a read, even when stored is 0000
                    doRead = addrMatch && !isGlobal;
                    answer = doRead;
                end
                `CRD_CMD_WRITE: begin
                    doWrite = (addrMatch && !isGlobal)
                        || (isGlobal && storedAddr == `CRD_GLOBAL_ADDR
                            && cmdFrame.index == `CRD_NODE_ADDR_IDX);
                    answer = doWrite;
                end
                `CRD_CMD_ENTER: begin
                    doEnter = addrMatch || isGlobal;
                    answer = addrMatch && !isGlobal;
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Register file update
    always_comb begin
        for (int i = 0; i < `CRD_FILE_DEPTH; i++) begin
            file_d[i] = file_q[i];
        end
        if (doWrite && inFile(cmdFrame.index)) begin
            file_d[slotOf(cmdFrame.index)] = cmdFrame.data;
            if (cmdFrame.index == `CRD_NODE_ADDR_IDX) begin
                // Upper nibble kept clear so the stored address compares cleanly
                file_d[slotOf(cmdFrame.index)] = {4'h0, cmdFrame.data[3:0]};
            end
        end
        // Enter sets the bit in the same slot that a later write may clear
        if (doEnter) begin
            file_d[slotOf(`CRD_COLLECT_IDX)][0] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `CRD_FILE_DEPTH; i++) begin
                file_q[i] <= `CRD_FILE_RST;
            end
        end else begin
            file_q <= file_d;
        end
    end

    // ==========================================================
    // Response build
    // Data is read from the next file state, so a write answers with the
    // value it just stored and a broadcast assignment echoes the new address.
    always_comb begin
        rspValid_d = answer;
        rsp_d = rsp_q;
        if (answer) begin
            rsp_d.nodeAddr = file_d[slotOf(`CRD_NODE_ADDR_IDX)][3:0];
            rsp_d.cmd = cmdFrame.cmd;
            if (doWrite && !inFile(cmdFrame.index)) begin
                rsp_d.dataHi = 8'h00;
                rsp_d.dataLo = 8'h00;
            end else if (doEnter) begin
                rsp_d.dataHi = 8'h00;
                rsp_d.dataLo = 8'h00;
            end else begin
                rsp_d.dataHi = readByte(nextIdx, file_d);
                rsp_d.dataLo = readByte(cmdFrame.index, file_d);
            end
        end
    end

    // Frame holds between answers; only the strobe drops back
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_q <= '0;
            rspValid_q <= 1'b0;
        end else begin
            rsp_q <= rsp_d;
            rspValid_q <= rspValid_d;
        end
    end

    assign rspValid = rspValid_q;
    assign rspFrame = rsp_q;
    assign nodeAddr = storedAddr;
    assign collectEnable = file_q[slotOf(`CRD_COLLECT_IDX)][0];

    // ==========================================================
    // Checks
    read_echo_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'h0 && addrMatch && !isGlobal
        |=> rspValid && rspFrame.cmd == 4'h0)
        else $error("read not echoed");
    read_drop_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'h0 && !addrMatch |=> !rspValid)
        else $error("read to other node answered");
    global_read_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'h0 && isGlobal |=> !rspValid)
        else $error("broadcast read answered");
    zero_read_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'h0 && addrMatch && !isGlobal
        && cmdFrame.index[7:4] != 4'h1 |=> rspFrame.dataLo == 8'h00)
        else $error("unreadable read not zero");
    resp_addr_a: assert property (@(posedge clk) disable iff (rst)
        rspValid |-> rspFrame.nodeAddr == nodeAddr)
        else $error("response address wrong");
    write_back_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'h8 && addrMatch && !isGlobal
        && cmdFrame.index == 8'h13 |=> rspValid && rspFrame.dataLo == $past(cmdFrame.data))
        else $error("write not read back");
    write_drop_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'h8 && !addrMatch && !isGlobal
        |=> !rspValid && $stable(nodeAddr))
        else $error("foreign write acted");
    global_enter_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == 4'hB && isGlobal |=> collectEnable && !rspValid)
        else $error("broadcast enter wrong");
    other_code_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd != 4'h0 && cmdFrame.cmd != 4'h8 && cmdFrame.cmd != 4'hB
        |=> !rspValid && $stable(nodeAddr) && $stable(collectEnable))
        else $error("unknown code acted");
    write_echo_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == `CRD_CMD_WRITE && addrMatch && !isGlobal
        |=> rspValid && rspFrame.cmd == `CRD_CMD_WRITE)
        else $error("write not echoed");
    zero_write_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == `CRD_CMD_WRITE && addrMatch && !isGlobal
        && cmdFrame.index[7:4] != 4'h1
        |=> rspValid && rspFrame.dataHi == 8'h00 && rspFrame.dataLo == 8'h00)
        else $error("unwritable write not zero");
    assign_echo_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == `CRD_CMD_WRITE && isGlobal
        && storedAddr == `CRD_GLOBAL_ADDR && cmdFrame.index == `CRD_NODE_ADDR_IDX
        |=> rspValid && rspFrame.dataLo == (8'h0F & $past(cmdFrame.data)))
        else $error("broadcast assignment not answered");
    late_assign_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == `CRD_CMD_WRITE && isGlobal
        && storedAddr != `CRD_GLOBAL_ADDR && cmdFrame.index == `CRD_NODE_ADDR_IDX
        |=> !rspValid && $stable(nodeAddr))
        else $error("late broadcast assignment accepted");
    node_enter_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == `CRD_CMD_ENTER && addrMatch && !isGlobal
        |=> collectEnable && rspValid && rspFrame.cmd == `CRD_CMD_ENTER)
        else $error("addressed enter wrong");
    foreign_enter_a: assert property (@(posedge clk) disable iff (rst)
        cmdValid && cmdFrame.cmd == `CRD_CMD_ENTER && !addrMatch && !isGlobal
        |=> !rspValid && $stable(collectEnable))
        else $error("foreign enter acted");
    cover_read_c: cover property (@(posedge clk) rspValid && rspFrame.cmd == 4'h0);
    cover_write_c: cover property (@(posedge clk) rspValid && rspFrame.cmd == 4'h8);
    cover_assign_c: cover property (@(posedge clk) $rose(nodeAddr != 4'h0));
    cover_enter_c: cover property (@(posedge clk) $rose(collectEnable));
endmodule // crd_command_decoder

//--- verification/crd_master_model.sv
// Behavioural bus master that issues command frames to the decoder
`timescale 1ns/1ps
module crd_master_model
    import crd_pkg::*;
(
    input wire logic clk, // Decoder clock
    output logic cmdValid, // Command strobe
    output crd_cmd_s cmdFrame // Command fields
);
    initial begin
        cmdValid = 1'b0;
        cmdFrame = '0;
    end
    // Fields are scrambled after the strobe so stale values never pass for a frame
    task automatic send(input logic [3:0] a, input logic [3:0] c, input logic [7:0] i,
                        input logic [7:0] d);
        @(posedge clk);
        #1;
        cmdValid = 1'b1;
        cmdFrame.nodeAddr = a;
        cmdFrame.cmd = c;
        cmdFrame.index = (c == 4'hB) ? 8'h00 : i;
        cmdFrame.data = (c == 4'h0 || c == 4'hB) ? 8'h00 : d;
        @(posedge clk);
        #1;
        cmdValid = 1'b0;
        cmdFrame = ~cmdFrame;
    endtask
endmodule // crd_master_model

//--- verification/crd_command_decoder_bench.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module crd_command_decoder_bench;
    import crd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid;
    crd_cmd_s cmdFrame;
    logic rspValid;
    crd_rsp_s rspFrame;
    logic [3:0] nodeAddr;
    logic collectEnable;
    int n_mismatch = 0;
    int comparisons = 0;
    crd_rsp_s lastRsp = '0;
    always #5 clk = ~clk;
    crd_master_model master_u (.clk(clk), .cmdValid(cmdValid), .cmdFrame(cmdFrame));
    crd_command_decoder dut_u (.clk(clk), .rst(rst), .cmdValid(cmdValid),
        .cmdFrame(cmdFrame), .rspValid(rspValid), .rspFrame(rspFrame),
        .nodeAddr(nodeAddr), .collectEnable(collectEnable));
    // ==========================================
    // Shared checks
    task automatic check(input logic [23:0] g, input logic [23:0] x);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // Response is sampled just after the edge that follows the command
    task automatic xfer(input logic [3:0] a, input logic [3:0] c, input logic [7:0] i,
                        input logic [7:0] d, input logic v, input logic [23:0] e);
        master_u.send(a, c, i, d);
        check({23'h0, rspValid}, {23'h0, v});
        if (v) lastRsp = e;
        check(rspFrame, lastRsp);
        @(posedge clk);
        #1;
        check({23'h0, rspValid}, 24'h0);
    endtask
    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_assign();
        xfer(4'h0, 4'h8, 8'h11, 8'hF5, 1'b1, 24'h580005);
        xfer(4'h0, 4'h8, 8'h11, 8'h07, 1'b0, 24'h0);
        check(nodeAddr, 4'h5);
    endtask
    task automatic t_write_read();
        xfer(4'h5, 4'h8, 8'h13, 8'h3C, 1'b1, 24'h58003C);
        xfer(4'h5, 4'h8, 8'h14, 8'h7E, 1'b1, 24'h58007E);
        xfer(4'h5, 4'h0, 8'h13, 8'h00, 1'b1, 24'h507E3C);
    endtask
    task automatic t_filter();
        xfer(4'h6, 4'h0, 8'h13, 8'h00, 1'b0, 24'h0);
        xfer(4'h0, 4'h0, 8'h13, 8'h00, 1'b0, 24'h0);
        xfer(4'h6, 4'h8, 8'h13, 8'h11, 1'b0, 24'h0);
        xfer(4'h0, 4'h8, 8'h13, 8'h22, 1'b0, 24'h0);
        xfer(4'h5, 4'h0, 8'h13, 8'h00, 1'b1, 24'h507E3C);
    endtask
    task automatic t_bounds();
        xfer(4'h5, 4'h0, 8'h40, 8'h00, 1'b1, 24'h500000);
        xfer(4'h5, 4'h8, 8'h40, 8'h99, 1'b1, 24'h580000);
        xfer(4'h5, 4'h8, 8'h1F, 8'hA1, 1'b1, 24'h5800A1);
        xfer(4'h5, 4'h0, 8'h12, 8'h00, 1'b1, 24'h503C00);
    endtask
    task automatic t_codes();
        for (int c = 1; c < 16; c++) begin
            if (c != 8 && c != 11) xfer(4'h5, 4'(c), 8'h13, 8'hFF, 1'b0, 24'h0);
        end
        xfer(4'h5, 4'h0, 8'h13, 8'h00, 1'b1, 24'h507E3C);
        check(collectEnable, 1'b0);
    endtask
    task automatic t_enter();
        xfer(4'h6, 4'hB, 8'h00, 8'h00, 1'b0, 24'h0);
        check(collectEnable, 1'b0);
        xfer(4'h5, 4'hB, 8'h00, 8'h00, 1'b1, 24'h5B0000);
        check(collectEnable, 1'b1);
        xfer(4'h5, 4'h8, 8'h12, 8'h00, 1'b1, 24'h583C00);
        check(collectEnable, 1'b0);
        xfer(4'h0, 4'hB, 8'h00, 8'h00, 1'b0, 24'h0);
        check(collectEnable, 1'b1);
        check(nodeAddr, 4'h5);
    endtask
    task automatic t_reset();
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        lastRsp = '0;
        check({nodeAddr, 3'h0, collectEnable, 7'h0, rspValid}, 16'h0000);
        check(rspFrame, 24'h0);
        xfer(4'h0, 4'h8, 8'h11, 8'h03, 1'b1, 24'h380003);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check({nodeAddr, 3'h0, collectEnable}, 8'h00);
        t_assign();
        t_write_read();
        t_filter();
        t_bounds();
        t_codes();
        t_enter();
        t_reset();
        stop_test();
    end
endmodule // crd_command_decoder_bench
